/* hw/ides_core.sv */
// Decode and execute slice: inc/dec with skip, inclusive OR, absolute jump.
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
//
// Each instruction is presented on instrWord with instrValid. Byte operations
// read the file memory in the first cycle and write back in the second, so a
// taken instruction always occupies two cycles (instrReady low for one).
// Function
// - Destination bit 0 writes working register, 1 writes the file register.
// - Decrement-skip subtracts one, stores per destination, zero result skips, flags untouched.
// - Increment-skip adds one, stores per destination, zero result skips, flags untouched.
// - Absolute jump loads 11-bit literal into PC low, page latch fills upper bits.
// - Absolute jump always takes two cycles and changes no flag.
// - OR-literal ORs working with 8-bit immediate into working, updates zero flag.
// - Plain increment adds one, stores per destination, updates zero, never skips.
// - OR-with-file ORs working and file register, stores per destination, updates zero.
// - Relative jump format carries a 9-bit immediate in its low bits.
// - Pointer offset format carries a pointer select bit and 6-bit immediate.
module ides_core
    import ides_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Instruction fetch
    input wire logic [INSTR_W-1:0] instrWord,
    input wire logic instrValid,
    output logic instrReady,
    // Program counter
    output logic [PC_W-1:0] progCounter,
    output logic pcLoad,
    output logic skipNext,
    // Decoded immediates
    output logic [REL_K_W-1:0] relOffset,
    output logic [PTR_K_W-1:0] ptrOffset,
    output logic ptrSelect,
    // Register port
    input wire logic [RADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [DATA_W-1:0] regRdata
);
    typedef struct packed {
        ides_state_t state;
        logic [INSTR_W-1:0] held;
        logic [DATA_W-1:0] working;
        logic zeroFlag;
        logic [PAGE_W-1:0] pageLatch;
        logic [PC_W-1:0] pc;
        logic pcLoad;
        logic skip;
        logic [REL_K_W-1:0] relOff;
        logic [PTR_K_W-1:0] ptrOff;
        logic ptrSel;
        logic [DATA_W-1:0] rdata;
    } ides_core_t;

    ides_core_t state_reg;
    ides_core_t state_next;

    logic [DATA_W-1:0] fileData;
    logic [DATA_W-1:0] aluResult;
    logic aluZero;
    logic fileWe;
    logic [5:0] heldOp;

    function automatic logic isByteOp(input logic [5:0] op);
        return op == OPC_OR_WORKING_FILE || op == OPC_INCREMENT_FILE
            || op == OPC_DECREMENT_SKIP_ZERO || op == OPC_INCREMENT_SKIP_ZERO;
    endfunction : isByteOp

    function automatic logic isSkipOp(input logic [5:0] op);
        return op == OPC_DECREMENT_SKIP_ZERO || op == OPC_INCREMENT_SKIP_ZERO;
    endfunction : isSkipOp

    assign heldOp = state_reg.held[INSTR_W-1:8];
    assign fileWe = state_reg.state == ST_FLUSH && isByteOp(heldOp)
        && state_reg.held[DEST_BIT];

    ides_file_ram u_ram (
        .ref_clk(ref_clk),
        .readAddr(instrWord[FADDR_W-1:0]),
        .readData(fileData),
        .writeEn(fileWe),
        .writeAddr(state_reg.held[FADDR_W-1:0]),
        .writeData(aluResult)
    );

    ides_alu u_alu (
        .opcode(heldOp),
        .workingVal(state_reg.working),
        .fileVal(fileData),
        .literalVal(state_reg.held[DATA_W-1:0]),
        .result(aluResult),
        .resultZero(aluZero)
    );

    // One cycle of stall while the second cycle completes
    assign instrReady = state_reg.state == ST_EXEC;

    always_comb begin
        state_next = state_reg;
        state_next.pcLoad = 1'b0;
        state_next.skip = 1'b0;
        case (state_reg.state)
            ST_EXEC: begin
                if (instrValid) begin
                    state_next.held = instrWord;
                    state_next.state = ST_FLUSH;
                    state_next.pc = PC_W'(state_reg.pc + 15'h0001);
                    if (instrWord[INSTR_W-1:9] == OPC_RELATIVE_JUMP) begin
                        state_next.relOff = instrWord[REL_K_W-1:0];
                    end
                    if (instrWord[INSTR_W-1:7] == OPC_POINTER_OFFSET) begin
                        state_next.ptrSel = instrWord[PTR_SEL_BIT];
                        state_next.ptrOff = instrWord[PTR_K_W-1:0];
                    end
                end
            end
            ST_FLUSH: begin
                state_next.state = ST_EXEC;
                state_next.held = NOP_WORD;
                if (state_reg.held[INSTR_W-1:11] == OPC_ABSOLUTE_JUMP) begin
                    state_next.pc = {state_reg.pageLatch[JUMP_PAGE_LO+:4],
                        state_reg.held[JUMP_K_W-1:0]};
                    state_next.pcLoad = 1'b1;
                end else if (heldOp == OPC_OR_LITERAL_WORKING) begin
                    state_next.working = aluResult;
                    state_next.zeroFlag = aluZero;
                end else if (isByteOp(heldOp)) begin
                    if (!state_reg.held[DEST_BIT]) begin
                        state_next.working = aluResult;
                    end
                    if (isSkipOp(heldOp)) begin
                        // Flags untouched; zero result drops the next word
                        if (aluZero) begin
                            state_next.skip = 1'b1;
                            state_next.pc = PC_W'(state_reg.pc + 15'h0001);
                        end
                    end else begin
                        state_next.zeroFlag = aluZero;
                    end
                end
            end
            default: begin
                state_next.state = ST_EXEC;
            end
        endcase
        // Software writes land last; a same-cycle execute result is overridden
        if (regWrite) begin
            case (regAddr)
                REG_WORKING: state_next.working = regWdata;
                REG_STATUS: state_next.zeroFlag = regWdata[ZERO_BIT];
                REG_PAGE_LATCH: state_next.pageLatch = regWdata[PAGE_W-1:0];
                default: begin
                end
            endcase
        end
        state_next.rdata = RESET_BYTE;
        if (regRead) begin
            case (regAddr)
                REG_WORKING: state_next.rdata = state_reg.working;
                REG_STATUS: state_next.rdata = {5'h00, state_reg.zeroFlag, 2'h0};
                REG_PAGE_LATCH: state_next.rdata = {1'b0, state_reg.pageLatch};
                REG_PC_LOW: state_next.rdata = state_reg.pc[7:0];
                REG_PC_HIGH: state_next.rdata = {1'b0, state_reg.pc[14:8]};
                REG_DECODE: state_next.rdata = {6'h00, state_reg.state};
                REG_REL_OFFSET: state_next.rdata = state_reg.relOff[7:0];
                REG_PTR_OFFSET: state_next.rdata = {state_reg.ptrSel, 1'b0,
                    state_reg.ptrOff};
                default: state_next.rdata = RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign progCounter = state_reg.pc;
    assign pcLoad = state_reg.pcLoad;
    assign skipNext = state_reg.skip;
    assign relOffset = state_reg.relOff;
    assign ptrOffset = state_reg.ptrOff;
    assign ptrSelect = state_reg.ptrSel;
    assign regRdata = state_reg.rdata;

    chk_jump_two_cycles: assert property (@(posedge ref_clk) disable iff (reset)
        (instrValid && instrReady && instrWord[13:11] == OPC_ABSOLUTE_JUMP)
        |=> !instrReady ##1 (pcLoad && instrReady))
        else $error("jump did not finish in two cycles");
    chk_jump_target: assert property (@(posedge ref_clk) disable iff (reset)
        (state_reg.state == ST_FLUSH && state_reg.held[13:11] == OPC_ABSOLUTE_JUMP
        && !regWrite)
        |=> progCounter == {$past(state_reg.pageLatch[6:3]), $past(state_reg.held[10:0])})
        else $error("jump target wrong");
    chk_skip_no_flag: assert property (@(posedge ref_clk) disable iff (reset)
        (state_reg.state == ST_FLUSH && isSkipOp(heldOp) && !regWrite)
        |=> $stable(state_reg.zeroFlag))
        else $error("skip op changed zero flag");
    chk_skip_on_zero: assert property (@(posedge ref_clk) disable iff (reset)
        (state_reg.state == ST_FLUSH && isSkipOp(heldOp)) |=> skipNext == $past(aluZero))
        else $error("skip does not follow zero result");
    chk_increment_file_op_no_skip: assert property (@(posedge ref_clk) disable iff (reset)
        (state_reg.state == ST_FLUSH && heldOp == OPC_INCREMENT_FILE) |=> !skipNext)
        else $error("plain increment skipped");
    chk_zero_update: assert property (@(posedge ref_clk) disable iff (reset)
        (state_reg.state == ST_FLUSH && !regWrite && (heldOp == OPC_OR_LITERAL_WORKING
        || heldOp == OPC_OR_WORKING_FILE || heldOp == OPC_INCREMENT_FILE))
        |=> state_reg.zeroFlag == ($past(aluResult) == 8'h00))
        else $error("zero flag wrong");
    chk_dest_working: assert property (@(posedge ref_clk) disable iff (reset)
        (state_reg.state == ST_FLUSH && isByteOp(heldOp) && !state_reg.held[7] && !regWrite)
        |=> state_reg.working == $past(aluResult))
        else $error("working register not written");
    chk_dest_file: assert property (@(posedge ref_clk) disable iff (reset)
        (state_reg.state == ST_FLUSH && isByteOp(heldOp) && state_reg.held[7] && !regWrite)
        |=> $stable(state_reg.working))
        else $error("file destination changed working register");
    chk_rel_field: assert property (@(posedge ref_clk) disable iff (reset)
        (instrValid && instrReady && instrWord[13:9] == OPC_RELATIVE_JUMP)
        |=> relOffset == $past(instrWord[8:0]))
        else $error("relative offset not captured");

    // Handshake and pulse shapes
    chk_take_stall: assert property (@(posedge ref_clk) disable iff (reset)
        (instrValid && instrReady)
        |=> !instrReady ##1 instrReady)
        else $error("take did not stall exactly one cycle");

    chk_flush_returns: assert property (@(posedge ref_clk) disable iff (reset)
        (state_reg.state == ST_FLUSH)
        |=> state_reg.state == ST_EXEC)
        else $error("second cycle did not return to execute");

    chk_load_pulse: assert property (@(posedge ref_clk) disable iff (reset)
        pcLoad
        |=> !pcLoad)
        else $error("jump load pulse too long");

    chk_skip_pulse: assert property (@(posedge ref_clk) disable iff (reset)
        skipNext
        |=> !skipNext)
        else $error("skip pulse too long");

    chk_load_source: assert property (@(posedge ref_clk) disable iff (reset)
        pcLoad
        |-> $past(state_reg.held[13:11]) == OPC_ABSOLUTE_JUMP)
        else $error("jump load pulse without a jump");

    chk_skip_source: assert property (@(posedge ref_clk) disable iff (reset)
        skipNext
        |-> isSkipOp($past(heldOp)))
        else $error("skip pulse from a non-skip operation");

    // Program counter movement, and working and zero flag held across a jump
    chk_pc_step: assert property (@(posedge ref_clk) disable iff (reset)
        (instrValid && instrReady)
        |=> progCounter == PC_W'($past(progCounter) + 15'h0001))
        else $error("program counter did not step on take");

    chk_skip_advance: assert property (@(posedge ref_clk) disable iff (reset)
        (state_reg.state == ST_FLUSH && isSkipOp(heldOp) && aluZero)
        |=> progCounter == PC_W'($past(progCounter) + 15'h0001))
        else $error("skip did not pass over next word");

    chk_pc_hold: assert property (@(posedge ref_clk) disable iff (reset)
        (state_reg.state == ST_FLUSH && isByteOp(heldOp) && !(isSkipOp(heldOp) && aluZero))
        |=> $stable(progCounter))
        else $error("program counter moved without skip");

    chk_jump_flags: assert property (@(posedge ref_clk) disable iff (reset)
        (state_reg.state == ST_FLUSH && state_reg.held[13:11] == OPC_ABSOLUTE_JUMP && !regWrite)
        |=> $stable(state_reg.zeroFlag) && $stable(state_reg.working))
        else $error("jump changed working or zero flag");

    // Results worked out from raw operands rather than the ALU's own flag
    chk_or_literal: assert property (@(posedge ref_clk) disable iff (reset)
        (state_reg.state == ST_FLUSH && heldOp == OPC_OR_LITERAL_WORKING && !regWrite)
        |=> state_reg.working == ($past(state_reg.working) | $past(state_reg.held[7:0])))
        else $error("literal OR result wrong");

    chk_or_zero: assert property (@(posedge ref_clk) disable iff (reset)
        (state_reg.state == ST_FLUSH && heldOp == OPC_OR_LITERAL_WORKING && !regWrite)
        |=> state_reg.zeroFlag == (state_reg.working == 8'h00))
        else $error("literal OR zero flag wrong");

    chk_or_file: assert property (@(posedge ref_clk) disable iff (reset)
        (state_reg.state == ST_FLUSH && heldOp == OPC_OR_WORKING_FILE)
        |-> aluResult == (state_reg.working | fileData))
        else $error("file OR result wrong");

    chk_inc_value: assert property (@(posedge ref_clk) disable iff (reset)
        (state_reg.state == ST_FLUSH && (heldOp == OPC_INCREMENT_FILE
        || heldOp == OPC_INCREMENT_SKIP_ZERO)) |-> aluResult == DATA_W'(fileData + 8'h01))
        else $error("increment result wrong");

    chk_dec_value: assert property (@(posedge ref_clk) disable iff (reset)
        (state_reg.state == ST_FLUSH && heldOp == OPC_DECREMENT_SKIP_ZERO)
        |-> aluResult == DATA_W'(fileData - 8'h01))
        else $error("decrement result wrong");

    chk_increment_file_op_zero: assert property (@(posedge ref_clk) disable iff (reset)
        (state_reg.state == ST_FLUSH && heldOp == OPC_INCREMENT_FILE && !regWrite)
        |=> state_reg.zeroFlag == ($past(fileData) == 8'hFF))
        else $error("increment zero flag wrong");

    chk_dec_skip: assert property (@(posedge ref_clk) disable iff (reset)
        (state_reg.state == ST_FLUSH && heldOp == OPC_DECREMENT_SKIP_ZERO)
        |=> skipNext == ($past(fileData) == 8'h01))
        else $error("decrement skip wrong");

    chk_inc_skip: assert property (@(posedge ref_clk) disable iff (reset)
        (state_reg.state == ST_FLUSH && heldOp == OPC_INCREMENT_SKIP_ZERO)
        |=> skipNext == ($past(fileData) == 8'hFF))
        else $error("increment skip wrong");

    chk_skip_nonzero: assert property (@(posedge ref_clk) disable iff (reset)
        (state_reg.state == ST_FLUSH && isSkipOp(heldOp) && aluResult != 8'h00)
        |=> !skipNext)
        else $error("skip on nonzero result");

    // Decoded immediates move only when their own format is taken
    chk_ptr_field: assert property (@(posedge ref_clk) disable iff (reset)
        (instrValid && instrReady && instrWord[13:7] == OPC_POINTER_OFFSET)
        |=> ptrOffset == $past(instrWord[5:0]) && ptrSelect == $past(instrWord[6]))
        else $error("pointer offset fields not captured");

    chk_rel_hold: assert property (@(posedge ref_clk) disable iff (reset)
        (instrValid && instrReady && instrWord[13:9] != OPC_RELATIVE_JUMP)
        |=> $stable(relOffset))
        else $error("relative offset changed by another format");

    chk_ptr_hold: assert property (@(posedge ref_clk) disable iff (reset)
        (instrValid && instrReady && instrWord[13:7] != OPC_POINTER_OFFSET)
        |=> $stable(ptrOffset) && $stable(ptrSelect))
        else $error("pointer offset changed by another format");
endmodule : ides_core

/* shared/ides_pkg.sv */
// Package for the instruction decode and execute slice: opcodes, fields, register map.
package ides_pkg;
    // Instruction word and data widths
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int PC_W = 15;
    localparam int FADDR_W = 7;
    localparam int JUMP_K_W = 11;
    localparam int REL_K_W = 9;
    localparam int PTR_K_W = 6;
    localparam int PAGE_W = 7;
    // Field positions
    localparam int DEST_BIT = 7;
    localparam int PTR_SEL_BIT = 6;
    localparam int JUMP_PAGE_LO = 3;
    // Opcodes: byte-oriented use bits 13:8, absolute jump 13:11, relative jump 13:9, pointer offset 13:7
    localparam logic [5:0] OPC_OR_WORKING_FILE = 6'h04;
    localparam logic [5:0] OPC_INCREMENT_FILE = 6'h0A;
    localparam logic [5:0] OPC_DECREMENT_SKIP_ZERO = 6'h0B;
    localparam logic [5:0] OPC_INCREMENT_SKIP_ZERO = 6'h0F;
    localparam logic [5:0] OPC_OR_LITERAL_WORKING = 6'h38;
    localparam logic [2:0] OPC_ABSOLUTE_JUMP = 3'h5;
    localparam logic [4:0] OPC_RELATIVE_JUMP = 5'h19;
    localparam logic [6:0] OPC_POINTER_OFFSET = 7'h62;
    localparam logic [INSTR_W-1:0] NOP_WORD = 14'h0000;
    // Register port
    localparam int RADDR_W = 4;
    localparam logic [RADDR_W-1:0] REG_WORKING = 4'h0;
    localparam logic [RADDR_W-1:0] REG_STATUS = 4'h1;
    localparam logic [RADDR_W-1:0] REG_PAGE_LATCH = 4'h2;
    localparam logic [RADDR_W-1:0] REG_PC_LOW = 4'h3;
    localparam logic [RADDR_W-1:0] REG_PC_HIGH = 4'h4;
    localparam logic [RADDR_W-1:0] REG_DECODE = 4'h5;
    localparam logic [RADDR_W-1:0] REG_REL_OFFSET = 4'h6;
    localparam logic [RADDR_W-1:0] REG_PTR_OFFSET = 4'h7;
    localparam int ZERO_BIT = 2;
    localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
    localparam logic [PC_W-1:0] RESET_PC = 15'h0000;
    // Execution states
    typedef enum logic [1:0] {
        ST_EXEC = 2'b00,
        ST_FLUSH = 2'b01
    } ides_state_t;
endpackage : ides_pkg

/* hw/ides_file_ram.sv */
// File register memory with registered read data.
`timescale 1ns/1ps
module ides_file_ram
    import ides_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Read port
    input wire logic [FADDR_W-1:0] readAddr,
    output logic [DATA_W-1:0] readData,
    // Write port
    input wire logic writeEn,
    input wire logic [FADDR_W-1:0] writeAddr,
    input wire logic [DATA_W-1:0] writeData
);
    logic [DATA_W-1:0] mem [0:(1<<FADDR_W)-1];

    // No reset on the array; contents are software's to initialise
    always_ff @(posedge ref_clk) begin
        if (writeEn) begin
            mem[writeAddr] <= writeData;
        end
        readData <= mem[readAddr];
    end
endmodule : ides_file_ram

/* hw/ides_alu.sv */
// Byte ALU for increment, decrement and inclusive OR.
`timescale 1ns/1ps
module ides_alu
    import ides_pkg::*;
(
    // Operation select
    input wire logic [5:0] opcode,
    // Operands
    input wire logic [DATA_W-1:0] workingVal,
    input wire logic [DATA_W-1:0] fileVal,
    input wire logic [DATA_W-1:0] literalVal,
    // Result
    output logic [DATA_W-1:0] result,
    output logic resultZero
);
    always_comb begin
        case (opcode)
            OPC_OR_WORKING_FILE: result = workingVal | fileVal;
            OPC_INCREMENT_FILE: result = DATA_W'(fileVal + 8'h01);
            OPC_INCREMENT_SKIP_ZERO: result = DATA_W'(fileVal + 8'h01);
            OPC_DECREMENT_SKIP_ZERO: result = DATA_W'(fileVal - 8'h01);
            OPC_OR_LITERAL_WORKING: result = workingVal | literalVal;
            default: result = fileVal;
        endcase
        resultZero = (result == 8'h00);
    end
endmodule : ides_alu

/* dv/tb_top.sv */
// Self-checking bench for the decode and execute slice.
`timescale 1ns/1ps
module tb_top;
    import ides_pkg::*;
    typedef struct packed {
        logic [5:0] opc;
        logic dst;
        logic [6:0] fa;
        logic [7:0] fv;
        logic [7:0] w;
        logic zPre;
        logic [7:0] expW;
        logic [7:0] expF;
        logic expZ;
        logic expSkip;
    } ides_row_t;
    logic ref_clk, reset, instrValid, instrReady, pcLoad, skipNext, ptrSelect;
    logic regWrite, regRead;
    logic [INSTR_W-1:0] instrWord;
    logic [PC_W-1:0] progCounter, pc0, pc1;
    logic [REL_K_W-1:0] relOffset;
    logic [PTR_K_W-1:0] ptrOffset;
    logic [RADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWdata, regRdata, v;
    logic [1:0] nl, ns;
    int num_errors, n_tests, cycles;
    // Opcode, d, f, file value, W, Z before, then W, file, Z and skip expected
    ides_row_t rows [11] = '{
        '{6'h0A, 1'b1, 7'h05, 8'h12, 8'h00, 1'b1, 8'h00, 8'h13, 1'b0, 1'b0},
        '{6'h0A, 1'b0, 7'h06, 8'hFF, 8'h55, 1'b0, 8'h00, 8'hFF, 1'b1, 1'b0},
        '{6'h0B, 1'b1, 7'h07, 8'h01, 8'h00, 1'b1, 8'h00, 8'h00, 1'b1, 1'b1},
        '{6'h0B, 1'b0, 7'h08, 8'h05, 8'h00, 1'b0, 8'h04, 8'h05, 1'b0, 1'b0},
        '{6'h0F, 1'b0, 7'h00, 8'hFF, 8'h11, 1'b0, 8'h00, 8'hFF, 1'b0, 1'b1},
        '{6'h0F, 1'b1, 7'h7F, 8'h7F, 8'h11, 1'b1, 8'h11, 8'h80, 1'b1, 1'b0},
        '{6'h04, 1'b0, 7'h10, 8'hF0, 8'h0F, 1'b1, 8'hFF, 8'hF0, 1'b0, 1'b0},
        '{6'h04, 1'b1, 7'h11, 8'h00, 8'h00, 1'b0, 8'h00, 8'h00, 1'b1, 1'b0},
        '{6'h38, 1'b1, 7'h7F, 8'h33, 8'h00, 1'b1, 8'hFF, 8'h33, 1'b0, 1'b0},
        '{6'h38, 1'b0, 7'h00, 8'h44, 8'h00, 1'b0, 8'h00, 8'h44, 1'b1, 1'b0},
        '{6'h38, 1'b0, 7'h05, 8'h99, 8'hA0, 1'b1, 8'hA5, 8'h99, 1'b0, 1'b0}
    };

    ides_core ides_core_i (.ref_clk(ref_clk), .reset(reset), .instrWord(instrWord),
        .instrValid(instrValid), .instrReady(instrReady), .progCounter(progCounter),
        .pcLoad(pcLoad), .skipNext(skipNext), .relOffset(relOffset), .ptrOffset(ptrOffset),
        .ptrSelect(ptrSelect), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata));

    always #10 ref_clk = ~ref_clk;

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : complete_run

    // Generous ceiling: the whole sequence needs well under two thousand cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic check(input logic [14:0] seen, input logic [14:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic regWr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask : regWr

    // Read data stand only in the cycle after the strobe
    task automatic regRd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        @(negedge ref_clk);
        d = regRdata;
    endtask : regRd

    task automatic readPc(output logic [14:0] pc);
        logic [7:0] lo, hi;
        regRd(REG_PC_LOW, lo);
        regRd(REG_PC_HIGH, hi);
        pc = {hi[6:0], lo};
    endtask : readPc

    // Holds the request until an edge with ready high, then counts the pulses
    task automatic exec(input logic [13:0] word, output logic [1:0] nLoad,
            output logic [1:0] nSkip);
        int k;
        nLoad = 2'd0;
        nSkip = 2'd0;
        @(posedge ref_clk);
        instrWord <= word;
        instrValid <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(negedge ref_clk);
            if (instrReady === 1'b1) break;
        end
        @(posedge ref_clk);
        instrValid <= 1'b0;
        for (k = 0; k < 3; k++) begin
            @(negedge ref_clk);
            if (k < 2) check(15'(instrReady), 15'(k));
            nLoad = nLoad + 2'(pcLoad);
            nSkip = nSkip + 2'(skipNext);
        end
    endtask : exec

    // File contents are unknown at start, so force all ones, wrap to zero, then OR in
    task automatic setFile(input logic [6:0] f, input logic [7:0] d);
        regWr(REG_WORKING, 8'hFF);
        exec({OPC_OR_WORKING_FILE, 1'b1, f}, nl, ns);
        exec({OPC_INCREMENT_FILE, 1'b1, f}, nl, ns);
        regWr(REG_WORKING, d);
        exec({OPC_OR_WORKING_FILE, 1'b1, f}, nl, ns);
    endtask : setFile

    task automatic readFile(input logic [6:0] f, output logic [7:0] d);
        regWr(REG_WORKING, 8'h00);
        exec({OPC_OR_WORKING_FILE, 1'b0, f}, nl, ns);
        regRd(REG_WORKING, d);
    endtask : readFile

    task automatic checkAllZero();
        int a;
        for (a = 0; a < 9; a++) begin
            regRd((a == 8) ? 4'hF : 4'(a), v);
            check(15'(v), 15'h0000);
        end
    endtask : checkAllZero

    initial begin
        ref_clk = 1'b0;
        reset = 1'b1;
        instrWord = '0;
        instrValid = 1'b0;
        regAddr = '0;
        regWdata = '0;
        regWrite = 1'b0;
        regRead = 1'b0;
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        checkAllZero();
        $display("Reset values done");
        foreach (rows[i]) begin
            setFile(rows[i].fa, rows[i].fv);
            regWr(REG_WORKING, rows[i].w);
            regWr(REG_STATUS, 8'(rows[i].zPre) << ZERO_BIT);
            readPc(pc0);
            exec({rows[i].opc, rows[i].dst, rows[i].fa}, nl, ns);
            check(15'(ns), 15'(rows[i].expSkip));
            readPc(pc1);
            check(pc1, pc0 + 15'h0001 + 15'(rows[i].expSkip));
            regRd(REG_WORKING, v);
            check(15'(v), 15'(rows[i].expW));
            regRd(REG_STATUS, v);
            check(15'(v[ZERO_BIT]), 15'(rows[i].expZ));
            readFile(rows[i].fa, v);
            check(15'(v), 15'(rows[i].expF));
            $display("Row %0d done", i);
        end
        regWr(REG_STATUS, 8'h04);
        regWr(REG_PAGE_LATCH, 8'hD5);
        regRd(REG_PAGE_LATCH, v);
        check(15'(v), 15'h0055);
        exec({OPC_ABSOLUTE_JUMP, 11'h7FF}, nl, ns);
        check(15'(nl), 15'h0001);
        readPc(pc1);
        check(pc1, 15'h57FF);
        check(progCounter, 15'h57FF);
        regRd(REG_STATUS, v);
        check(15'(v), 15'h0004);
        regWr(REG_PAGE_LATCH, 8'h07);
        exec({OPC_ABSOLUTE_JUMP, 11'h000}, nl, ns);
        readPc(pc1);
        check(pc1, 15'h0000);
        $display("Jump test done");
        exec({OPC_RELATIVE_JUMP, 9'h1A5}, nl, ns);
        check(15'(relOffset), 15'h01A5);
        exec({OPC_POINTER_OFFSET, 1'b1, 6'h2A}, nl, ns);
        regRd(REG_PTR_OFFSET, v);
        check(15'(v), 15'h00AA);
        exec({OPC_POINTER_OFFSET, 1'b0, 6'h15}, nl, ns);
        check(15'({ptrSelect, ptrOffset}), 15'h0015);
        $display("Format test done");
        // Valid held high: the word is refused while busy, so two takes in four edges
        setFile(7'h03, 8'h40);
        @(posedge ref_clk);
        instrWord <= {OPC_INCREMENT_FILE, 1'b1, 7'h03};
        instrValid <= 1'b1;
        repeat (4) @(posedge ref_clk);
        instrValid <= 1'b0;
        readFile(7'h03, v);
        check(15'(v), 15'h0042);
        readPc(pc0);
        regWr(REG_PC_LOW, 8'hFF);
        regWr(4'hF, 8'hFF);
        readPc(pc1);
        check(pc1, pc0);
        $display("Back to back and read-only test done");
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        @(negedge ref_clk);
        check({instrReady, pcLoad, skipNext, 12'h000}, 15'h4000);
        check(progCounter, RESET_PC);
        checkAllZero();
        $display("Mid-run reset test done");
        complete_run();
    end
endmodule : tb_top
